// File: hw/ocm_defs.vh
// Register offsets, field positions and reset values of the memory ports.
`ifndef OCM_DEFS_VH
`define OCM_DEFS_VH

// ==========================================================================
// Register offsets on the plain register port (word index)
// ==========================================================================
`define OCM_OFF_INSTR_CTRL   2'h0
`define OCM_OFF_DATA_CTRL    2'h1
`define OCM_OFF_FILL_ADDR    2'h2
`define OCM_OFF_FILL_DATA    2'h3

// ==========================================================================
// Control register fields
// ==========================================================================
`define OCM_CTRL_AUTO_BIT    3
`define OCM_CTRL_WAIT_LO     5
`define OCM_CTRL_WAIT_HI     7
`define OCM_CTRL_RST         8'h01

// ==========================================================================
// Fill registers
// ==========================================================================
`define OCM_FILL_ADDR_W      22
`define OCM_FILL_ADDR_RST    22'h000000
`define OCM_FILL_DATA_RST    32'h00000000

// ==========================================================================
// Timing
// ==========================================================================
// Cycles from a shared rising edge to the edge on which the synchronised
// RAM clock shows its rise.
`define OCM_SYNC_LAT         4'h3

`endif

// File: hw/ocm_fixed_latency_ports.v
// Fixed-latency instruction and data side memory port controllers.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "ocm_defs.vh"

// ==========================================================================
// One read port with its own ratio tracking
// ==========================================================================
module ocm_read_port #(
  parameter AW  = 21,
  parameter DW  = 32,
  parameter GAP = 1
) (
  // Clock, reset, enable
  input  wire          mclk_in,
  input  wire          rst_n_in,
  input  wire          ce_in,
  // Ratio control
  input  wire [7:0]    ctrl_in,
  input  wire          ram_clk_in,
  output wire          shared_edge_out,
  output wire [2:0]    wait_field_out,
  // Core side
  input  wire          req_in,
  input  wire [AW-1:0] addr_in,
  input  wire          flush_in,
  output wire          ready_out,
  output reg           valid_out,
  output reg  [DW-1:0] data_out,
  // RAM side
  output reg  [AW-1:0] ram_addr_out,
  input  wire [DW-1:0] ram_data_in
);

  // Two stages synchronise the RAM clock and the third finds its rise.
  reg       sync1_q;
  reg       sync2_q;
  reg       sync3_q;
  reg [3:0] cnt_q;
  reg [3:0] meas_q;
  reg [3:0] ratio_q;
  reg       s1_q;
  reg       s2_q;
  wire      auto_mode;
  wire [3:0] prog_ratio;
  wire [3:0] ratio;
  wire      rise;
  wire      accept;
  wire [3:0] meas_ratio;
  wire [3:0] ratio_next;
  wire [3:0] wait_full;

  // Phase that the counter holds in the cycle after a detected rise. The
  // rise is seen a fixed number of edges late, so that latency is reduced
  // modulo the ratio; the loop is bounded because the latency is small.
  function [3:0] phase_after;
    input [3:0] n;
    reg   [3:0] p;
    integer     i;
    begin
      p = `OCM_SYNC_LAT;
      for (i = 0; i < 4; i = i + 1) begin
        if (n != 4'h0 && p >= n) begin
          p = p - n;
        end
      end
      phase_after = p;
    end
  endfunction

  // A measured period of zero cycles means that no rise was seen yet.
  function [3:0] period_or_one;
    input [3:0] m;
    begin
      period_or_one = (m == 4'h0) ? 4'h1 : m;
    end
  endfunction

  assign auto_mode  = ctrl_in[`OCM_CTRL_AUTO_BIT];
  assign prog_ratio = {2'b00, ctrl_in[`OCM_CTRL_WAIT_HI:`OCM_CTRL_WAIT_HI-1]}
                      + 4'h1;
  assign ratio      = auto_mode ? ratio_q : prog_ratio;
  assign meas_ratio = period_or_one(meas_q);
  assign ratio_next = auto_mode ? meas_ratio : prog_ratio;
  assign rise       = sync2_q & ~sync3_q;
  // The next rising edge of the processor clock is also a RAM clock edge.
  assign shared_edge_out = (cnt_q >= ratio - 4'h1);
  assign wait_full       = {ratio[2:0], 1'b0} - 4'h1;
  assign wait_field_out  = wait_full[2:0];

  // Address stage must be free or handing over at a shared edge; with GAP 2 it must be free, and the data stage free or handing over.
  assign ready_out = (GAP == 1) ? (~s1_q | shared_edge_out)
                                : (~s1_q & (~s2_q | shared_edge_out));
  assign accept    = req_in & ready_out & ~flush_in;

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      cnt_q   <= 4'h0;
      meas_q  <= 4'h0;
      ratio_q <= 4'h1;
    end else if (ce_in) begin
      sync1_q <= ram_clk_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (rise) begin
        // Every seen rise realigns the phase, so that a manual ratio also
        // puts its shared edges on the rising edges of the RAM clock.
        meas_q <= 4'h1;
        cnt_q  <= phase_after(ratio_next);
        if (auto_mode) begin
          ratio_q <= meas_ratio;
        end
      end else begin
        if (meas_q != 4'hF) begin
          meas_q <= meas_q + 4'h1;
        end
        cnt_q <= shared_edge_out ? 4'h0 : cnt_q + 4'h1;
      end
      if (auto_mode && sync2_q && sync3_q && meas_q > 4'h8) begin
        ratio_q <= 4'h1;   // RAM clock too fast to see: treat as 1:1.
      end
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s1_q         <= 1'b0;
      s2_q         <= 1'b0;
      valid_out    <= 1'b0;
      data_out     <= {DW{1'b0}};
      ram_addr_out <= {AW{1'b0}};
    end else if (ce_in) begin
      valid_out <= 1'b0;
      if (flush_in) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        if (shared_edge_out) begin
          s2_q <= s1_q;
          if (s2_q) begin
            valid_out <= 1'b1;
            data_out  <= ram_data_in;
          end
        end
        if (accept) begin
          s1_q         <= 1'b1;
          ram_addr_out <= addr_in;
        end else if (shared_edge_out) begin
          s1_q <= 1'b0;
        end
      end
    end
  end

endmodule // ocm_read_port

// ==========================================================================
// Top level: both ports, fill path and register port
// ==========================================================================
module ocm_fixed_latency_ports #(
  parameter IAW = 21,
  parameter DAW = 21
) (
  // Clock, reset, enable
  input  wire            mclk_in,
  input  wire            rst_n_in,
  input  wire            ce_in,
  // Register port
  input  wire [1:0]      reg_addr_in,
  input  wire [31:0]     reg_wdata_in,
  input  wire            reg_wr_in,
  input  wire            reg_rd_in,
  output reg  [31:0]     reg_rdata_out,
  // Instruction fetch, core side
  input  wire            fetch_req_in,
  input  wire [IAW:0]    fetch_addr_in,
  input  wire            fetch_flush_in,
  output wire            fetch_ready_out,
  output wire            fetch_valid_out,
  output wire [63:0]     fetch_data_out,
  // Instruction RAM
  input  wire            instr_ram_clock_in,
  output wire [IAW-1:0]  instr_read_address_out,
  input  wire [63:0]     instr_read_data_in,
  output reg  [IAW-1:0]  instr_write_address_out,
  output reg  [31:0]     instr_write_data_out,
  output wire            instr_even_write_enable_out,
  output wire            instr_odd_write_enable_out,
  // Data load, core side
  input  wire            load_req_in,
  input  wire [DAW-1:0]  load_addr_in,
  output wire            load_ready_out,
  output wire            load_valid_out,
  output wire [31:0]     load_data_out,
  // Data RAM
  input  wire            data_ram_clock_in,
  output wire [DAW-1:0]  data_read_address_out,
  input  wire [31:0]     data_read_data_in
);

  reg  [7:0]  instr_port_control_q;
  reg  [7:0]  data_port_control_q;
  reg  [`OCM_FILL_ADDR_W-1:0] instr_fill_address_q;
  reg  [31:0] instr_fill_data_q;
  reg         even_en_q;
  reg         odd_en_q;
  reg         wr_act_q;
  reg         wr_even_q;
  reg         wr_odd_q;
  wire        i_se;
  wire [2:0]  i_wait;
  wire [2:0]  d_wait;
  reg  [31:0] rd_d;

  ocm_read_port #(.AW(IAW), .DW(64), .GAP(1)) u_instr (
    .mclk_in         (mclk_in),
    .rst_n_in        (rst_n_in),
    .ce_in           (ce_in),
    .ctrl_in         (instr_port_control_q),
    .ram_clk_in      (instr_ram_clock_in),
    .shared_edge_out (i_se),
    .wait_field_out  (i_wait),
    .req_in          (fetch_req_in),
    .addr_in         (fetch_addr_in[IAW:1]),
    .flush_in        (fetch_flush_in),
    .ready_out       (fetch_ready_out),
    .valid_out       (fetch_valid_out),
    .data_out        (fetch_data_out),
    .ram_addr_out    (instr_read_address_out),
    .ram_data_in     (instr_read_data_in)
  );

  ocm_read_port #(.AW(DAW), .DW(32), .GAP(2)) u_data (
    .mclk_in         (mclk_in),
    .rst_n_in        (rst_n_in),
    .ce_in           (ce_in),
    .ctrl_in         (data_port_control_q),
    .ram_clk_in      (data_ram_clock_in),
    .shared_edge_out (),
    .wait_field_out  (d_wait),
    .req_in          (load_req_in),
    .addr_in         (load_addr_in),
    .flush_in        (1'b0),
    .ready_out       (load_ready_out),
    .valid_out       (load_valid_out),
    .data_out        (load_data_out),
    .ram_addr_out    (data_read_address_out),
    .ram_data_in     (data_read_data_in)
  );

  // Enables are held from the fill write until the next shared edge, so
  // the instruction RAM sees each fill word on exactly one of its edges.
  assign instr_even_write_enable_out = wr_act_q & wr_even_q;
  assign instr_odd_write_enable_out  = wr_act_q & wr_odd_q;

  // A fill write arriving while the previous one waits is dropped.
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      instr_port_control_q    <= `OCM_CTRL_RST;
      data_port_control_q     <= `OCM_CTRL_RST;
      instr_fill_address_q    <= `OCM_FILL_ADDR_RST;
      instr_fill_data_q       <= `OCM_FILL_DATA_RST;
      even_en_q               <= 1'b1;
      odd_en_q                <= 1'b0;
      wr_act_q                <= 1'b0;
      wr_even_q               <= 1'b0;
      wr_odd_q                <= 1'b0;
      instr_write_address_out <= {IAW{1'b0}};
      instr_write_data_out    <= 32'h00000000;
    end else if (ce_in) begin
      if (wr_act_q && i_se) begin
        wr_act_q <= 1'b0;
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `OCM_OFF_INSTR_CTRL: begin
            instr_port_control_q <= reg_wdata_in[7:0];
          end
          `OCM_OFF_DATA_CTRL: begin
            data_port_control_q <= reg_wdata_in[7:0];
          end
          `OCM_OFF_FILL_ADDR: begin
            instr_fill_address_q <= reg_wdata_in[`OCM_FILL_ADDR_W-1:0];
            even_en_q            <= ~reg_wdata_in[0];
            odd_en_q             <= reg_wdata_in[0];
          end
          `OCM_OFF_FILL_DATA: begin
            instr_fill_data_q <= reg_wdata_in;
            if (!wr_act_q || i_se) begin
              wr_act_q                <= 1'b1;
              wr_even_q               <= even_en_q;
              wr_odd_q                <= odd_en_q;
              instr_write_address_out <=
                instr_fill_address_q[`OCM_FILL_ADDR_W-1:1];
              instr_write_data_out    <= reg_wdata_in;
              even_en_q               <= ~even_en_q;
              odd_en_q                <= ~odd_en_q;
              instr_fill_address_q    <= instr_fill_address_q
                                         + 22'h000001;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Auto mode reads back twice the detected ratio minus one in the wait field.
  always @* begin
    rd_d = 32'h00000000;
    case (reg_addr_in)
      `OCM_OFF_INSTR_CTRL: begin
        rd_d[7:0] = instr_port_control_q;
        if (instr_port_control_q[`OCM_CTRL_AUTO_BIT]) begin
          rd_d[`OCM_CTRL_WAIT_HI:`OCM_CTRL_WAIT_LO] = i_wait;
        end
      end
      `OCM_OFF_DATA_CTRL: begin
        rd_d[7:0] = data_port_control_q;
        if (data_port_control_q[`OCM_CTRL_AUTO_BIT]) begin
          rd_d[`OCM_CTRL_WAIT_HI:`OCM_CTRL_WAIT_LO] = d_wait;
        end
      end
      `OCM_OFF_FILL_ADDR: begin
        rd_d[`OCM_FILL_ADDR_W-1:0] = instr_fill_address_q;
      end
      default: begin
        rd_d = instr_fill_data_q;
      end
    endcase
  end

  // Read data stand for exactly one cycle after the read strobe.
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rd_d : 32'h00000000;
    end
  end

endmodule // ocm_fixed_latency_ports

// File: tb/ocm_ram_model.sv
// Synchronous read-only RAM model for one memory port.
`timescale 1ns/1ps
module ocm_ram_model #(
  parameter        AW   = 21,
  parameter        DW   = 64,
  parameter [31:0] MASK = 32'h00000000
) (
  // RAM clock
  input  wire logic          clk_in,
  // Read port
  input  wire logic [AW-1:0] addr_in,
  output logic      [DW-1:0] data_out
);
  logic [31:0] word;
  logic [63:0] row;
  wire  [AW-1:0] held;
  // Hold time: an address launched on a shared edge is seen only after it.
  assign #1 held = addr_in;
  assign word = {{(32-AW){1'b0}}, held} ^ MASK;
  assign row  = {word, ~word};
  // The address is sampled on the port's own clock, and the data change on that same edge.
  always @(posedge clk_in) begin
    data_out <= row[63:64-DW];
  end
endmodule // ocm_ram_model

// File: tb/ocm_fixed_latency_ports_assertions.sv
// Concurrent checks on the memory port controller pins.
`timescale 1ns/1ps
module ocm_flp_chk #(
  parameter IAW = 21,
  parameter DAW = 21
) (
  // Clock, reset, enable
  input logic           mclk_in,
  input logic           rst_n_in,
  input logic           ce_in,
  // Register port
  input logic [1:0]     reg_addr_in,
  input logic [31:0]    reg_wdata_in,
  input logic           reg_wr_in,
  // Fetch port
  input logic           fetch_req_in,
  input logic [IAW:0]   fetch_addr_in,
  input logic           fetch_flush_in,
  input logic           fetch_ready_out,
  input logic           fetch_valid_out,
  input logic [IAW-1:0] instr_read_address_out,
  input logic [31:0]    instr_write_data_out,
  input logic           instr_even_write_enable_out,
  input logic           instr_odd_write_enable_out,
  // Load port
  input logic           load_req_in,
  input logic [DAW-1:0] load_addr_in,
  input logic           load_ready_out,
  input logic           load_valid_out,
  input logic [DAW-1:0] data_read_address_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // Helper terms
  logic           f_acc, l_acc, fill, we_any;
  logic [IAW-1:0] f_row;
  assign f_acc  = fetch_req_in && fetch_ready_out && !fetch_flush_in && ce_in;
  assign l_acc  = load_req_in && load_ready_out && ce_in;
  assign fill   = reg_wr_in && reg_addr_in == 2'h3 && ce_in;
  assign we_any = instr_even_write_enable_out || instr_odd_write_enable_out;
  assign f_row  = fetch_addr_in[IAW:1];
  // ==========================================
  // Properties
  AST_FILL_ONE: assert property (fill && !we_any |=>
    instr_even_write_enable_out != instr_odd_write_enable_out)
    else $error("fill write did not raise exactly one enable");
  AST_FILL_DATA: assert property (fill && !we_any |=>
    instr_write_data_out == $past(reg_wdata_in))
    else $error("fill word not presented to the RAM");
  AST_WE_EXCL: assert property (!(instr_even_write_enable_out &&
    instr_odd_write_enable_out)) else $error("both write enables high");
  AST_FETCH_ADDR: assert property (f_acc |=>
    instr_read_address_out == $past(f_row))
    else $error("fetch address not driven after accept");
  AST_IADDR_HOLD: assert property (!f_acc |=>
    $stable(instr_read_address_out)) else $error("fetch address moved");
  AST_LOAD_ADDR: assert property (l_acc |=>
    data_read_address_out == $past(load_addr_in))
    else $error("load address not driven after accept");
  AST_FETCH_DONE: assert property (f_acc |->
    ##[1:16] (fetch_valid_out || fetch_flush_in))
    else $error("fetch never completed");
  AST_LOAD_DONE: assert property (l_acc |-> ##[2:16] load_valid_out)
    else $error("load never completed");
  AST_LOAD_GAP: assert property (load_valid_out |=> !load_valid_out)
    else $error("loads completed on adjacent cycles");
endmodule // ocm_flp_chk

bind ocm_fixed_latency_ports ocm_flp_chk #(.IAW(IAW), .DAW(DAW)) u_chk (.*);

// File: tb/tb.sv
// Directed testbench for the fixed-latency memory port controllers.
`timescale 1ns/1ps
`include "ocm_defs.vh"
module tb;
  // ==========================================
  // Pins, clocks and result queues
  logic        mclk_in, rst_n_in, ce_in, reg_wr_in, reg_rd_in;
  logic [1:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rd;
  logic        fetch_req_in, fetch_flush_in, fetch_ready_out, fetch_valid_out;
  logic        load_req_in, load_ready_out, load_valid_out;
  logic [21:0] fetch_addr_in;
  logic [63:0] fetch_data_out, instr_read_data_in, fq[$];
  logic        instr_ram_clock_in, data_ram_clock_in, div_clk, isel, dsel;
  logic        instr_even_write_enable_out, instr_odd_write_enable_out;
  logic [20:0] instr_read_address_out, instr_write_address_out;
  logic [20:0] load_addr_in, data_read_address_out;
  logic [31:0] instr_write_data_out, load_data_out, data_read_data_in, lq[$];
  int          fail_count, comparisons, cyc, acc, a0, k, fs[$], ls[$];

  // Both RAM clocks rise together with the processor clock.
  initial begin
    mclk_in = 1'b0;
    div_clk = 1'b0;
    forever begin
      #10 mclk_in = 1'b1;
      div_clk <= ~div_clk;
      #10 mclk_in = 1'b0;
    end
  end
  assign instr_ram_clock_in = isel ? div_clk : mclk_in;
  assign data_ram_clock_in  = dsel ? div_clk : mclk_in;

  ocm_fixed_latency_ports DUT (.*);
  ocm_ram_model #(.DW(64)) u_iram (.clk_in(instr_ram_clock_in),
    .addr_in(instr_read_address_out), .data_out(instr_read_data_in));
  ocm_ram_model #(.DW(32), .MASK(32'hC3C3C3C3)) u_dram (
    .clk_in(data_ram_clock_in), .addr_in(data_read_address_out),
    .data_out(data_read_data_in));

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (fetch_valid_out === 1'b1) begin
      fq.push_back(fetch_data_out);
      fs.push_back(cyc);
    end
    if (load_valid_out === 1'b1) begin
      lq.push_back(load_data_out);
      ls.push_back(cyc);
    end
  end

  // ==========================================
  // Tasks
  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
    d = reg_rdata_out;
  endtask
  task automatic go(input bit ld, input logic [21:0] a);
    if (ld) load_req_in <= 1'b1;
    else fetch_req_in <= 1'b1;
    load_addr_in <= a[20:0];
    fetch_addr_in <= a;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk_in);
      if ((ld ? load_ready_out : fetch_ready_out) === 1'b1) break;
    end
    if (k == 20) begin
      fail_count++;
      report_and_stop();
    end
    acc = cyc;
  endtask
  task automatic stop_wait(input int n);
    fetch_req_in <= 1'b0;
    load_req_in <= 1'b0;
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic slow(input bit ins);
    @(posedge mclk_in);
    if (!div_clk) @(posedge mclk_in);
    if (ins) isel <= 1'b1;
    else dsel <= 1'b1;
  endtask
  function automatic logic [63:0] expd(input bit ld, input logic [20:0] r);
    logic [31:0] w;
    w = {11'h000, r};
    expd = ld ? {32'h0, w ^ 32'hC3C3C3C3} : {w, ~w};
  endfunction
  task automatic expect_q(input bit ld, input int n, input logic [20:0] r,
                          input int lo, hi, gap);
    logic [63:0] d;
    int s, p;
    chk("result count", n, ld ? lq.size() : fq.size());
    for (int i = 0; i < n; i++) begin
      d = ld ? {32'h0, lq.pop_front()} : fq.pop_front();
      s = ld ? ls.pop_front() : fs.pop_front();
      chk("read data", expd(ld, r + i), d);
      chk("result timing", 1, i ? s - p == gap : s - a0 >= lo && s - a0 <= hi);
      p = s;
    end
  endtask

  // ==========================================
  // Scenarios
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, fetch_req_in, fetch_flush_in} = '0;
    {load_req_in, isel, dsel, reg_addr_in, reg_wdata_in} = '0;
    {fetch_addr_in, load_addr_in} = '0;
    ce_in = 1'b1;
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_read(i[1:0], rd);
      chk("reset value", i < 2 ? `OCM_CTRL_RST : 32'h0, rd);
    end
    reg_write(2'h2, 32'h00000005);
    for (int i = 0; i < 2; i++) begin
      reg_write(2'h3, 32'hA0 + i);
      #1 chk("odd enable", i == 0, instr_odd_write_enable_out);
      chk("even enable", i == 1, instr_even_write_enable_out);
      chk("write address", 21'h2 + i, instr_write_address_out);
      chk("write data", 32'hA0 + i, instr_write_data_out);
      @(posedge mclk_in);
      #1 chk("enables drop", 0, we_pair());
    end
    reg_read(2'h2, rd);
    chk("fill address", 32'h7, rd);
    reg_read(2'h3, rd);
    chk("fill data", 32'hA1, rd);
    @(posedge mclk_in);
    go(0, 22'h000010);
    a0 = acc;
    go(0, 22'h000012);
    stop_wait(8);
    expect_q(0, 2, 21'h8, 3, 3, 1);
    go(1, 22'h000040);
    a0 = acc;
    go(1, 22'h000041);
    stop_wait(8);
    expect_q(1, 2, 21'h40, 3, 3, 2);
    go(0, 22'h000020);
    fetch_req_in <= 1'b0;
    fetch_flush_in <= 1'b1;
    @(posedge mclk_in);
    fetch_flush_in <= 1'b0;
    stop_wait(8);
    chk("flushed fetches", 0, fq.size());
    go(0, 22'h000030);
    a0 = acc;
    stop_wait(8);
    expect_q(0, 1, 21'h18, 3, 3, 1);
    slow(0);
    reg_write(2'h1, 32'h00000008);
    repeat (24) @(posedge mclk_in);
    reg_read(2'h1, rd);
    chk("detected ratio", 32'h68, rd);
    go(1, 22'h000050);
    a0 = acc;
    go(1, 22'h000051);
    stop_wait(20);
    expect_q(1, 2, 21'h50, 2, 8, 4);
    slow(1);
    reg_write(2'h0, 32'h00000061);
    reg_read(2'h0, rd);
    chk("manual ratio", 32'h61, rd);
    go(0, 22'h000080);
    a0 = acc;
    go(0, 22'h000082);
    stop_wait(20);
    expect_q(0, 2, 21'h40, 2, 8, 2);
    report_and_stop();
  end
  function automatic logic [1:0] we_pair();
    we_pair = {instr_odd_write_enable_out, instr_even_write_enable_out};
  endfunction
endmodule // tb
